/* hw/gpp_port.sv */
/*
 * General-purpose pin port: direction, pad, interrupt and masked data logic.
 * Assumes pin inputs synchronous to clk_i and one command per cycle.
 */
`timescale 1ns/1ps
module gpp_port
    import gpp_pkg::*;
#(
    parameter int NUM_PINS = 8
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Command port.
    input  wire gpp_req_t     req_i,
    input  wire logic [7:0]   rd_addr_mask_i,
    output logic [7:0]        rd_data_o,
    input  wire logic [2:0]   pin_number_i,
    output gpp_pin_cfg_t      pin_cfg_o,
    output logic [7:0]        int_raw_o,
    output logic [7:0]        int_masked_o,
    output logic [7:0]        int_mask_o,
    output logic              irq_o,
    // Peripheral side.
    input  wire logic [7:0]   periph_out_i,
    input  wire logic [7:0]   periph_oe_i,
    output logic [7:0]        periph_in_o,
    // Pads.
    input  wire logic [7:0]   pad_in_i,
    output logic [7:0]        pad_out_o,
    output logic [7:0]        pad_oe_o,
    output gpp_pad_t [7:0]    pad_ctl_o
);

    if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
        $error("NUM_PINS out of range");
    end

    localparam logic [7:0] PIN_EXISTS = 8'((16'h1 << NUM_PINS) - 16'h1); // [R1]

    // Pin-type decoding shared by the pad drivers and the checks.
    function automatic logic is_open_drain(input logic [2:0] pin_type);
        return pin_type inside {PT_OD, PT_OD_WPU, PT_OD_WPD};
    endfunction

    function automatic logic has_pull_up(input logic [2:0] pin_type);
        return pin_type inside {PT_STD_WPU, PT_OD_WPU};
    endfunction

    function automatic logic has_pull_down(input logic [2:0] pin_type);
        return pin_type inside {PT_STD_WPD, PT_OD_WPD};
    endfunction

    gpp_pin_cfg_t [7:0] cfg_q, cfg_d;
    logic [7:0]         dout_q, dout_d;
    logic [7:0]         mask_q, mask_d;
    logic [7:0]         stat_q, stat_d;
    logic [7:0]         prev_q;
    logic [7:0]         rd_q, rd_d;
    logic [7:0]         hit;

    always_comb begin
        cfg_d  = cfg_q;
        dout_d = dout_q;
        mask_d = mask_q;
        stat_d = stat_q;
        hit    = '0;
        for (int i = 0; i < MAX_PINS; i++) begin
            if (req_i.pin_select_mask[i] && PIN_EXISTS[i]) begin // [R9]
                unique case (req_i.cmd)
                    GPP_CMD_DIR_SET:  cfg_d[i].dir = req_i.value[1:0]; // [R14]
                    GPP_CMD_TRIG_SET: cfg_d[i].trig = req_i.value[2:0]; // [R3]
                    GPP_CMD_PAD_SET: begin
                        cfg_d[i].drive    = req_i.value[1:0]; // [R4]
                        cfg_d[i].pin_type = req_i.value[6:4]; // [R6] [R7]
                    end
                    GPP_CMD_INT_EN:  mask_d[i] = 1'b1; // [R17]
                    GPP_CMD_INT_DIS: mask_d[i] = 1'b0; // [R17]
                    GPP_CMD_INT_CLR: stat_d[i] = 1'b0; // [R18]
                    GPP_CMD_WRITE:   dout_d[i] = req_i.value[i]; // [R11]
                    default: ;
                endcase
            end
            // Trigger detection; a set in the same cycle beats a clear.
            if (PIN_EXISTS[i] && cfg_q[i].dir == DIR_SW_INPUT) begin // [R3]
                unique case (cfg_q[i].trig)
                    TRIG_FALLING:  hit[i] = prev_q[i] & ~pad_in_i[i];
                    TRIG_RISING:   hit[i] = ~prev_q[i] & pad_in_i[i];
                    TRIG_BOTH:     hit[i] = prev_q[i] ^ pad_in_i[i];
                    TRIG_LOW_LVL:  hit[i] = ~pad_in_i[i];
                    TRIG_HIGH_LVL: hit[i] = pad_in_i[i];
                    default:       hit[i] = 1'b0;
                endcase
            end
            if (hit[i]) begin
                stat_d[i] = 1'b1;
            end
        end
        rd_d = pad_in_i & rd_addr_mask_i & PIN_EXISTS; // [R10] [R12]
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < MAX_PINS; i++) begin
                cfg_q[i] <= '{dir: RST_DIR, trig: RST_TRIG, drive: RST_DRV, pin_type: RST_PT}; // [R2] [R4] [R6] [R7]
            end
            dout_q <= 8'h00;
            mask_q <= 8'h00;
            stat_q <= 8'h00;
            prev_q <= 8'h00;
            rd_q   <= 8'h00;
        end else begin
            cfg_q  <= cfg_d;
            dout_q <= dout_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            prev_q <= pad_in_i;
            rd_q   <= rd_d;
        end
    end

    always_comb begin
        for (int i = 0; i < MAX_PINS; i++) begin
            logic periph;
            logic od;
            logic drv_val;
            logic drv_en;
            periph  = cfg_q[i].dir == DIR_PERIPHERAL_CONTROL; // [R8]
            od      = is_open_drain(cfg_q[i].pin_type); // [R7]
            drv_val = periph ? periph_out_i[i] : dout_q[i];
            drv_en  = PIN_EXISTS[i] && (periph ? periph_oe_i[i] : cfg_q[i].dir == DIR_SW_OUTPUT);
            pad_out_o[i] = od ? 1'b0 : drv_val;
            pad_oe_o[i]  = drv_en && (!od || !drv_val);
            pad_ctl_o[i].pull_up   = has_pull_up(cfg_q[i].pin_type); // [R6]
            pad_ctl_o[i].pull_down = has_pull_down(cfg_q[i].pin_type); // [R6]
            pad_ctl_o[i].slew_ctl  = cfg_q[i].drive == DRV_8MA_SC; // [R5]
            pad_ctl_o[i].drive     = (cfg_q[i].drive == DRV_8MA_SC) ? DRV_8MA : cfg_q[i].drive; // [R4]
            periph_in_o[i] = periph & pad_in_i[i];
        end
    end

    assign rd_data_o    = rd_q;
    assign pin_cfg_o    = cfg_q[pin_number_i]; // [R13] [R14] [R15]
    assign int_raw_o    = stat_q; // [R19]
    assign int_masked_o = stat_q & mask_q; // [R19]
    assign int_mask_o   = mask_q;
    assign irq_o        = |(stat_q & mask_q); // [R20]

    a_read_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
        rd_data_o == ($past(pad_in_i) & $past(rd_addr_mask_i) & PIN_EXISTS))
        else $error("masked read wrong");
    a_write_unsel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        req_i.cmd == GPP_CMD_WRITE |=> dout_q == (($past(dout_q) & ~($past(req_i.pin_select_mask) & PIN_EXISTS))
        | ($past(req_i.value) & $past(req_i.pin_select_mask) & PIN_EXISTS)))
        else $error("masked write wrong");
    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R20]
        irq_o == |(int_raw_o & int_mask_o)) else $error("irq mismatch");
    a_clear_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R18]
        req_i.cmd == GPP_CMD_INT_CLR && !(|hit) |=> (stat_q & $past(req_i.pin_select_mask) & PIN_EXISTS) == 8'h00)
        else $error("clear failed");
    a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
        |hit |=> (stat_q & $past(hit)) == $past(hit)) else $error("trigger lost");
    a_int_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R17]
        req_i.cmd == GPP_CMD_INT_EN |=> (mask_q & $past(req_i.pin_select_mask) & PIN_EXISTS)
        == ($past(req_i.pin_select_mask) & PIN_EXISTS)) else $error("enable failed");
    a_int_disable: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R17]
        req_i.cmd == GPP_CMD_INT_DIS |=> (mask_q & $past(req_i.pin_select_mask) & PIN_EXISTS) == 8'h00)
        else $error("disable failed");

    a_masked_view: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R19]
        int_masked_o == (int_raw_o & int_mask_o))
        else $error("masked status wrong");

    // Per-pin checks; pins beyond NUM_PINS must stay idle.
    for (genvar p = 0; p < MAX_PINS; p++) begin : g_pin_chk
        logic sense;
        assign sense = PIN_EXISTS[p] && cfg_q[p].dir == DIR_SW_INPUT;

        // Pad drive and termination.
        a_slew_only8: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
            pad_ctl_o[p].slew_ctl
            |-> pad_ctl_o[p].drive == DRV_8MA)
            else $error("slew without 8mA drive");

        a_input_noout: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
            cfg_q[p].dir == DIR_SW_INPUT
            |-> !pad_oe_o[p])
            else $error("input pin driven");

        a_od_nohigh: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
            is_open_drain(cfg_q[p].pin_type) && pad_oe_o[p]
            |-> !pad_out_o[p])
            else $error("open drain drove high");

        a_pull_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
            pad_ctl_o[p].pull_up
            |-> !pad_ctl_o[p].pull_down)
            else $error("both pulls enabled");

        a_periph_in: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
            periph_in_o[p]
            == (cfg_q[p].dir == DIR_PERIPHERAL_CONTROL && pad_in_i[p]))
            else $error("peripheral input wrong");

        a_periph_out: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
            PIN_EXISTS[p] && cfg_q[p].dir == DIR_PERIPHERAL_CONTROL && !is_open_drain(cfg_q[p].pin_type)
            |-> pad_oe_o[p] == periph_oe_i[p] && pad_out_o[p] == periph_out_i[p])
            else $error("peripheral drive wrong");

        a_sw_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
            PIN_EXISTS[p] && cfg_q[p].dir == DIR_SW_OUTPUT && !is_open_drain(cfg_q[p].pin_type)
            |-> pad_oe_o[p] && pad_out_o[p] == dout_q[p])
            else $error("output drive wrong");

        a_absent_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
            !PIN_EXISTS[p]
            |-> !pad_oe_o[p] && !stat_q[p] && !rd_data_o[p])
            else $error("absent pin active");

        // Configuration writes land on selected pins only.
        a_dir_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R14]
            req_i.cmd == GPP_CMD_DIR_SET && req_i.pin_select_mask[p] && PIN_EXISTS[p]
            |=> cfg_q[p].dir == $past(req_i.value[1:0]))
            else $error("direction not stored");

        a_trig_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R15]
            req_i.cmd == GPP_CMD_TRIG_SET && req_i.pin_select_mask[p] && PIN_EXISTS[p]
            |=> cfg_q[p].trig == $past(req_i.value[2:0]))
            else $error("trigger not stored");

        a_drive_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
            req_i.cmd == GPP_CMD_PAD_SET && req_i.pin_select_mask[p] && PIN_EXISTS[p]
            |=> cfg_q[p].drive == $past(req_i.value[1:0]))
            else $error("drive not stored");

        a_type_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
            req_i.cmd == GPP_CMD_PAD_SET && req_i.pin_select_mask[p] && PIN_EXISTS[p]
            |=> cfg_q[p].pin_type == $past(req_i.value[6:4]))
            else $error("pin type not stored");

        a_write_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
            req_i.cmd == GPP_CMD_WRITE && req_i.pin_select_mask[p] && PIN_EXISTS[p]
            |=> dout_q[p] == $past(req_i.value[p]))
            else $error("pin write lost");

        a_unsel_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
            req_i.cmd != GPP_CMD_NONE && !req_i.pin_select_mask[p]
            |=> $stable(cfg_q[p]) && $stable(dout_q[p]) && $stable(mask_q[p]))
            else $error("unselected pin changed");

        a_cfg_view: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
            pin_number_i == 3'(p)
            |-> pin_cfg_o == cfg_q[p])
            else $error("pin query wrong");

        // Trigger detection and status.
        a_rise_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            sense && cfg_q[p].trig == TRIG_RISING && !prev_q[p] && pad_in_i[p]
            |=> stat_q[p])
            else $error("rising edge missed");

        a_fall_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            sense && cfg_q[p].trig == TRIG_FALLING && prev_q[p] && !pad_in_i[p]
            |=> stat_q[p])
            else $error("falling edge missed");

        a_both_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            sense && cfg_q[p].trig == TRIG_BOTH && prev_q[p] != pad_in_i[p]
            |=> stat_q[p])
            else $error("edge missed");

        a_low_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            sense && cfg_q[p].trig == TRIG_LOW_LVL && !pad_in_i[p]
            |=> stat_q[p])
            else $error("low level missed");

        a_high_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            sense && cfg_q[p].trig == TRIG_HIGH_LVL && pad_in_i[p]
            |=> stat_q[p])
            else $error("high level missed");

        a_no_spurious: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            !hit[p] && !stat_q[p]
            |=> !stat_q[p])
            else $error("status set without trigger");

        a_out_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
            !sense && !stat_q[p]
            |=> !stat_q[p])
            else $error("status set off input mode");

        a_clear_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R18]
            req_i.cmd == GPP_CMD_INT_CLR && req_i.pin_select_mask[p] && !hit[p]
            |=> !stat_q[p])
            else $error("pin clear failed");

        a_irq_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R20]
            stat_q[p] && mask_q[p]
            |-> irq_o)
            else $error("pending pin without irq");
    end

endmodule

/* hw/gpp_pkg.sv */
/*
 * Constants, encodings and carrier types for the general-purpose pin port.
 * Assumes one system clock and a controller that issues one command per cycle.
 */
// Overview of operation
// (R1) Up to eight pins, each configured separately.
// (R2) Every pin is an input after reset.
// (R3) Input pins interrupt on a selected trigger.
// (R4) Drive strength 2, 4 or 8 mA; reset 2 mA.
// (R5) Slew control only with 8 mA drive.
// (R6) Weak pull-up or pull-down; none after reset.
// (R7) Optional open drain; push-pull after reset.
// (R8) Pin is general-purpose or peripheral; general after reset.
// (R9) Group operations use an eight-bit pin mask.
// (R10) Masked read returns selected pins, others zero.
// (R11) Masked write updates selected pins together only.
// (R12) Data mask comes from the access address bits.
// (R13) Single-pin queries use a pin number 0-7.
// (R14) Direction mode per pin, readable back.
// (R15) Interrupt trigger per pin, readable back.
// (R16) Controller keeps inputs stable while changing triggers.
// (R17) Interrupt mask set or cleared per pin group.
// (R18) Latched interrupts cleared per group in one access.
// (R19) Raw and masked status readable, low eight bits.
// (R20) Interrupt output high while unmasked status pending.
package gpp_pkg;

    localparam int MAX_PINS = 8;

    // Direction modes.
    localparam logic [1:0] DIR_SW_INPUT           = 2'h0;
    localparam logic [1:0] DIR_SW_OUTPUT          = 2'h1;
    localparam logic [1:0] DIR_PERIPHERAL_CONTROL = 2'h2;

    // Interrupt trigger codes.
    localparam logic [2:0] TRIG_FALLING   = 3'h0;
    localparam logic [2:0] TRIG_RISING    = 3'h1;
    localparam logic [2:0] TRIG_BOTH      = 3'h2;
    localparam logic [2:0] TRIG_LOW_LVL   = 3'h3;
    localparam logic [2:0] TRIG_HIGH_LVL  = 3'h4;

    // Drive strengths.
    localparam logic [1:0] DRV_2MA    = 2'h0;
    localparam logic [1:0] DRV_4MA    = 2'h1;
    localparam logic [1:0] DRV_8MA    = 2'h2;
    localparam logic [1:0] DRV_8MA_SC = 2'h3;

    // Pin types.
    localparam logic [2:0] PT_STD     = 3'h0;
    localparam logic [2:0] PT_STD_WPU = 3'h1;
    localparam logic [2:0] PT_STD_WPD = 3'h2;
    localparam logic [2:0] PT_OD      = 3'h3;
    localparam logic [2:0] PT_OD_WPU  = 3'h4;
    localparam logic [2:0] PT_OD_WPD  = 3'h5;

    // Reset values.
    localparam logic [1:0] RST_DIR  = DIR_SW_INPUT;
    localparam logic [2:0] RST_TRIG = TRIG_FALLING;
    localparam logic [1:0] RST_DRV  = DRV_2MA;
    localparam logic [2:0] RST_PT   = PT_STD;

    // Commands.
    typedef enum logic [3:0] {
        GPP_CMD_NONE     = 4'h0,
        GPP_CMD_DIR_SET  = 4'h1,
        GPP_CMD_TRIG_SET = 4'h2,
        GPP_CMD_PAD_SET  = 4'h3,
        GPP_CMD_INT_EN   = 4'h4,
        GPP_CMD_INT_DIS  = 4'h5,
        GPP_CMD_INT_CLR  = 4'h6,
        GPP_CMD_WRITE    = 4'h7
    } gpp_cmd_t;

    typedef struct packed {
        gpp_cmd_t   cmd;
        logic [7:0] pin_select_mask;
        logic [7:0] value;
    } gpp_req_t;

    typedef struct packed {
        logic [1:0] dir;
        logic [2:0] trig;
        logic [1:0] drive;
        logic [2:0] pin_type;
    } gpp_pin_cfg_t;

    typedef struct packed {
        logic pull_up;
        logic pull_down;
        logic slew_ctl;
        logic [1:0] drive;
    } gpp_pad_t;

endpackage

/* testbench/gpp_pad_model.sv */
/*
 * Board-side model of the eight pads of the pin port.
 * Assumes the bench drives the far end of each pin through ext_val_i and ext_en_i.
 */
`timescale 1ns/1ps
module gpp_pad_model
    import gpp_pkg::*;
(
    // Port side.
    input  wire logic [7:0]     out_i,
    input  wire logic [7:0]     oe_i,
    input  wire gpp_pad_t [7:0] ctl_i,
    // Board side.
    input  wire logic [7:0]     ext_val_i,
    input  wire logic [7:0]     ext_en_i,
    output logic [7:0]          pad_o
);
    // An undriven pin with no pull shows a value that the bench does not expect.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe_i[i]) pad_o[i] = out_i[i];
            else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
            else if (ctl_i[i].pull_up) pad_o[i] = 1'b1;
            else if (ctl_i[i].pull_down) pad_o[i] = 1'b0;
            else pad_o[i] = ~ext_val_i[i];
        end
    end
endmodule

/* testbench/testbench.sv */
/*
 * Self-checking bench for the pin port.
 * Assumes the pad model on the far side and commands issued at the falling edge.
 */
`timescale 1ns/1ps
module testbench;
    import gpp_pkg::*;
    logic           clk, rst_n, irq;
    gpp_req_t       req;
    logic [7:0]     rd_mask, rd_data, raw, msk, imask, pdout, pdoe, pdin, pad;
    logic [7:0]     ext_val, ext_en, p_out, p_oe;
    logic [2:0]     pin_num;
    gpp_pin_cfg_t   cfg;
    gpp_pad_t [7:0] ctl;
    logic [2:0]     trigs [5] = '{TRIG_FALLING, TRIG_RISING, TRIG_BOTH, TRIG_LOW_LVL, TRIG_HIGH_LVL};
    int             n_fail = 0;
    int             n_checks = 0;

    gpp_port dut_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .rd_addr_mask_i(rd_mask), .rd_data_o(rd_data),
        .pin_number_i(pin_num), .pin_cfg_o(cfg), .int_raw_o(raw), .int_masked_o(msk), .int_mask_o(imask),
        .irq_o(irq), .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(pdin), .pad_in_i(pad),
        .pad_out_o(pdout), .pad_oe_o(pdoe), .pad_ctl_o(ctl));
    gpp_pad_model pads_u (.out_i(pdout), .oe_i(pdoe), .ctl_i(ctl), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .pad_o(pad));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic cmd(input gpp_cmd_t c, input logic [7:0] m, input logic [7:0] v);
        req = '{c, m, v};
        @(negedge clk);
        req = '{GPP_CMD_NONE, 8'h00, 8'h00};
        @(negedge clk);
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        req = '{GPP_CMD_NONE, 8'h00, 8'h00};
        rd_mask = 8'h00;
        pin_num = 3'h0;
        ext_val = 8'h00;
        ext_en = 8'hff;
        p_out = 8'h00;
        p_oe = 8'h00;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("oe", 8'h00, pdoe);
        for (int i = 0; i < 8; i++) begin
            pin_num = 3'(i);
            #1;
            chk("cfg", 8'({RST_DIR, RST_TRIG, RST_DRV, RST_PT} >> 2), 8'(cfg >> 2));
            chk("type", 8'(RST_PT), 8'(cfg.pin_type));
            chk("ctl", 8'h00, 8'(ctl[i][4:2]));
        end
        $display("reset test done");
        cmd(GPP_CMD_DIR_SET, 8'h09, {6'h0, DIR_SW_OUTPUT});
        cmd(GPP_CMD_WRITE, 8'h09, 8'hff);
        chk("oe", 8'h09, pdoe);
        chk("out", 8'h09, pdout & 8'h09);
        cmd(GPP_CMD_WRITE, 8'h08, 8'h00);
        chk("out", 8'h01, pdout & 8'h09);
        rd_mask = 8'h0b;
        ext_val = 8'h02;
        repeat (2) @(negedge clk);
        chk("rd", 8'h03, rd_data);
        pin_num = 3'h3;
        #1;
        chk("dir", 8'(DIR_SW_OUTPUT), 8'(cfg.dir));
        $display("data test done");
        cmd(GPP_CMD_INT_EN, 8'h04, 8'h00);
        chk("imask", 8'h04, imask);
        pin_num = 3'h2;
        foreach (trigs[k]) begin
            ext_val[2] = 1'b1;
            repeat (3) @(negedge clk);
            cmd(GPP_CMD_TRIG_SET, 8'h04, {5'h0, trigs[k]});
            cmd(GPP_CMD_INT_CLR, 8'hff, 8'h00);
            @(negedge clk);
            chk("trig", 8'(trigs[k]), 8'(cfg.trig));
            chk("raw_hi", {5'h0, trigs[k] == TRIG_HIGH_LVL, 2'h0}, raw);
            ext_val[2] = 1'b0;
            repeat (3) @(negedge clk);
            chk("raw_lo", {5'h0, trigs[k] != TRIG_RISING, 2'h0}, raw);
            chk("irq", 8'(trigs[k] != TRIG_RISING), 8'(irq));
        end
        cmd(GPP_CMD_INT_DIS, 8'h04, 8'h00);
        chk("masked", 8'h00, msk);
        chk("irq", 8'h00, 8'(irq));
        cmd(GPP_CMD_INT_CLR, 8'hfb, 8'h00);
        chk("raw", 8'h04, raw);
        cmd(GPP_CMD_INT_CLR, 8'h04, 8'h00);
        chk("raw", 8'h00, raw);
        $display("interrupt test done");
        cmd(GPP_CMD_PAD_SET, 8'h04, {1'b0, PT_OD_WPU, 2'h0, DRV_8MA_SC});
        chk("drv", 8'(DRV_8MA_SC), 8'(cfg.drive));
        chk("drive", 8'(DRV_8MA), 8'(ctl[2].drive));
        chk("ctl", 8'h05, 8'(ctl[2][4:2]));
        cmd(GPP_CMD_PAD_SET, 8'h02, {1'b0, PT_STD_WPD, 2'h0, DRV_4MA});
        chk("ctl", 8'h02, 8'(ctl[1][4:2]));
        ext_en[2] = 1'b0;
        cmd(GPP_CMD_DIR_SET, 8'h04, {6'h0, DIR_SW_OUTPUT});
        cmd(GPP_CMD_WRITE, 8'h04, 8'h00);
        chk("od0", 8'h04, pdoe & 8'h04);
        cmd(GPP_CMD_WRITE, 8'h04, 8'h04);
        chk("od1", 8'h00, pdoe & 8'h04);
        rd_mask = 8'h04;
        repeat (2) @(negedge clk);
        chk("od_rd", 8'h04, rd_data);
        $display("pad test done");
        p_out = 8'h10;
        p_oe = 8'h10;
        cmd(GPP_CMD_DIR_SET, 8'h10, {6'h0, DIR_PERIPHERAL_CONTROL});
        pin_num = 3'h4;
        #1;
        chk("dir", 8'(DIR_PERIPHERAL_CONTROL), 8'(cfg.dir));
        chk("p_oe", 8'h10, pdoe & 8'h10);
        chk("p_in", 8'h10, pdin);
        $display("peripheral test done");
        conclude();
    end
endmodule
